//--- src/cwrb_defines.vh
`ifndef CWRB_DEFINES_VH
`define CWRB_DEFINES_VH
`define CWRB_CTRL_WBEN_BIT  3
`define CWRB_CTRL_CEN_BIT   2
`define CWRB_CTRL_RESET     32'h0000_0000
`define CWRB_WB_DEPTH       8
`define CWRB_RB_ENTRIES     4
`define CWRB_RB_WORDS       8
`define CWRB_SIZE_WORD      2'h1
`define CWRB_SIZE_HALF      2'h2
`define CWRB_SIZE_LINE      2'h3
`endif

//--- src/cwrb_top.v
`timescale 1ns/1ps
`default_nettype none
`include "cwrb_defines.vh"
module cwrb_top #(
   parameter DEPTH = `CWRB_WB_DEPTH
) (
   input  wire         clk_i,          // Core clock
   input  wire         rst_b_i,        // Async reset, active low
   input  wire         ctrl_we_i,      // System control write strobe
   input  wire [31:0]  ctrl_wdata_i,   // System control write data
   output reg  [31:0]  ctrl_rdata_o,   // System control readback
   input  wire         st_valid_i,     // Store request
   input  wire [31:0]  st_addr_i,      // Store address
   input  wire [127:0] st_data_i,      // Store data, up to 16 bytes
   input  wire [15:0]  st_be_i,        // Store byte enables
   input  wire         st_multi_i,     // Next word of a store-multiple
   input  wire         st_cache_hit_i, // Store hit a data cache
   input  wire         st_prot_ok_i,   // Protection allows the store
   input  wire         st_bufable_i,   // Translation bufferable attribute
   input  wire         cb_valid_i,     // Dirty-line copyback request
   input  wire [31:0]  cb_addr_i,      // Copyback address
   input  wire [127:0] cb_data_i,      // Copyback data
   input  wire [15:0]  cb_be_i,        // Copyback byte enables
   input  wire         drain_i,        // Drain write buffer request
   output reg          cache_dirty_o,  // Mark the hit line dirty
   output reg          stall_o,        // Core stall
   output reg          wb_empty_o,     // Write buffer empty
   output reg          mem_wr_o,       // External write request
   output reg  [31:0]  mem_waddr_o,    // External write address
   output reg  [127:0] mem_wdata_o,    // External write data
   output reg  [15:0]  mem_wbe_o,      // External write byte enables
   input  wire         mem_wack_i,     // External write done
   input  wire         mem_abort_i,    // External abort, ignored for buffered and unbuffered writes
   input  wire         alloc_i,        // Read buffer allocate
   input  wire [1:0]   alloc_entry_i,  // Target entry
   input  wire [1:0]   alloc_size_i,   // One word, half or full line
   input  wire [31:0]  alloc_addr_i,   // Allocate virtual address
   input  wire         tl_hit_i,       // Translation lookaside hit
   input  wire         tl_viol_i,      // Access violation
   input  wire         inval_i,        // Invalidate read buffer
   input  wire         inval_all_i,    // Invalidate all entries
   input  wire [1:0]   inval_entry_i,  // Entry to invalidate
   output reg          fill_req_o,     // Read buffer fill word request
   output reg  [31:0]  fill_addr_o,    // Fill word address
   input  wire         fill_ack_i,     // Fill word returned
   input  wire [31:0]  fill_data_i,    // Fill word data
   input  wire         fill_abort_i,   // Fill saw a data abort
   input  wire         ld_valid_i,     // Load request
   input  wire [31:0]  ld_addr_i,      // Load virtual address
   output reg          ld_hit_o,       // Load served by read buffer
   output reg  [31:0]  ld_data_o,      // Read buffer load data
   output reg          ld_abort_o      // Load hit an aborted entry
);
   localparam S_IDLE = 3'b001;
   localparam S_SEND = 3'b010;
   localparam S_WAIT = 3'b100;
   localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   reg  [31:0]  ctrl;
   reg  [31:0]  q_addr [0:DEPTH-1];
   reg  [127:0] q_data [0:DEPTH-1];
   reg  [15:0]  q_be   [0:DEPTH-1];
   reg  [AW-1:0] wp;
   reg  [AW-1:0] rp;
   reg  [AW:0]  cnt;
   reg  [2:0]   state;
   reg          last_multi;
   reg  [AW-1:0] last_idx;
   reg          ub_pend;
   reg          ub_fly;
   reg  [31:0]  ub_addr;
   reg  [127:0] ub_data;
   reg  [15:0]  ub_be;

   reg  [26:0]  rb_tag  [0:`CWRB_RB_ENTRIES-1];
   reg  [31:0]  rb_word [0:`CWRB_RB_ENTRIES*`CWRB_RB_WORDS-1];
   reg  [7:0]   rb_val  [0:`CWRB_RB_ENTRIES-1];
   reg  [3:0]   rb_abt;
   reg  [3:0]   rb_busy;
   reg          f_act;
   reg  [1:0]   f_ent;
   reg  [2:0]   f_idx;
   reg  [2:0]   f_last;

   wire wben      = ctrl[`CWRB_CTRL_WBEN_BIT];
   wire st_in     = st_valid_i & ~(st_cache_hit_i & st_prot_ok_i);
   wire st_buf    = st_in & wben & st_bufable_i;
   wire st_unbuf  = st_in & ~st_buf;
   // Head entry may already be on the bus, so never merge into it
   wire merge_ok  = st_buf & st_multi_i & last_multi & (cnt > 1) &
                    (q_addr[last_idx][31:5] == st_addr_i[31:5]);
   wire full      = (cnt == DEPTH);
   wire cb_take   = cb_valid_i & ~full;
   wire st_take   = st_buf & ~cb_valid_i & (merge_ok | ~full);
   wire st_push   = st_take & ~merge_ok;
   wire ub_issue  = ub_pend & (cnt == 0) & (state == S_IDLE);
   wire q_issue   = (cnt != 0) & (state == S_IDLE);
   wire q_pop     = (state == S_WAIT) & mem_wack_i & ~ub_fly;
   wire ub_done   = ub_fly & (state == S_WAIT) & mem_wack_i;
   wire ub_cap    = st_unbuf & ~ub_pend;
   wire [AW:0] next_cnt = cnt + {{AW{1'b0}}, cb_take | st_push} - {{AW{1'b0}}, q_pop};

   function [AW-1:0] inc;
      input [AW-1:0] p;
      begin
         inc = (p == DEPTH-1) ? {AW{1'b0}} : p + 1'b1;
      end
   endfunction

   function [26:0] line_of;
      input [31:0] a;
      begin
         line_of = a[31:5];
      end
   endfunction

   // Mask of words an allocate covers within its line
   function [7:0] span;
      input [1:0]  sz;
      input [31:0] a;
      begin
         case (sz)
            `CWRB_SIZE_LINE: span = 8'hff;
            `CWRB_SIZE_HALF: span = a[4] ? 8'hf0 : 8'h0f;
            default:         span = 8'h01 << a[4:2];
         endcase
      end
   endfunction

   wire [7:0] a_span = span(alloc_size_i, alloc_addr_i);
   wire [2:0] a_first = (alloc_size_i == `CWRB_SIZE_LINE) ? 3'h0 :
                        (alloc_size_i == `CWRB_SIZE_HALF) ? {alloc_addr_i[4], 2'h0} :
                        alloc_addr_i[4:2];
   wire [2:0] a_last  = (alloc_size_i == `CWRB_SIZE_LINE) ? 3'h7 :
                        (alloc_size_i == `CWRB_SIZE_HALF) ? {alloc_addr_i[4], 2'h3} :
                        alloc_addr_i[4:2];
   wire a_stall = alloc_i & (~tl_hit_i | rb_busy[alloc_entry_i] | f_act);
   wire a_go    = alloc_i & tl_hit_i & ~tl_viol_i & ~a_stall;

   reg  [3:0] l_hitv;
   reg        l_busy;
   reg  [1:0] l_ent;
   integer    k;
   always @* begin
      l_hitv = 4'h0;
      l_busy = 1'b0;
      l_ent  = 2'h0;
      for (k = 0; k < `CWRB_RB_ENTRIES; k = k + 1) begin
         if (rb_tag[k] == line_of(ld_addr_i) && rb_val[k][ld_addr_i[4:2]]) begin
            l_hitv[k] = 1'b1;
            l_ent     = k[1:0];
         end
         if (rb_busy[k] && rb_tag[k] == line_of(ld_addr_i)) begin
            l_busy = 1'b1;
         end
      end
   end
   wire l_stall = ld_valid_i & l_busy;

   wire next_stall = (st_buf & ~st_take) | st_unbuf & ~ub_done |
                     (drain_i & ~(next_cnt == 0 & state != S_WAIT)) |
                     a_stall | l_stall;

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl          <= `CWRB_CTRL_RESET;
         ctrl_rdata_o  <= `CWRB_CTRL_RESET;
         wp            <= {AW{1'b0}};
         rp            <= {AW{1'b0}};
         cnt           <= {(AW+1){1'b0}};
         state         <= S_IDLE;
         last_multi    <= 1'b0;
         last_idx      <= {AW{1'b0}};
         ub_pend       <= 1'b0;
         ub_fly        <= 1'b0;
         ub_addr       <= 32'h0000_0000;
         ub_data       <= 128'h0;
         ub_be         <= 16'h0000;
         cache_dirty_o <= 1'b0;
         stall_o       <= 1'b0;
         wb_empty_o    <= 1'b1;
         mem_wr_o      <= 1'b0;
         mem_waddr_o   <= 32'h0000_0000;
         mem_wdata_o   <= 128'h0;
         mem_wbe_o     <= 16'h0000;
      end else begin
         if (ctrl_we_i) begin
            ctrl         <= ctrl_wdata_i;
            ctrl_rdata_o <= ctrl_wdata_i;
         end
         cache_dirty_o <= st_valid_i & st_cache_hit_i & st_prot_ok_i;
         stall_o       <= next_stall;
         cnt           <= next_cnt;
         wb_empty_o    <= (next_cnt == 0) & ~(ub_pend & ~ub_done) & ~ub_cap;
         if (cb_take) begin
            q_addr[wp] <= cb_addr_i;
            q_data[wp] <= cb_data_i;
            q_be[wp]   <= cb_be_i;
            wp         <= inc(wp);
            last_multi <= 1'b0;
         end else if (st_take) begin
            if (merge_ok) begin
               q_data[last_idx] <= (q_data[last_idx] & ~{{8{st_be_i[15]}}, {8{st_be_i[14]}},
                                   {8{st_be_i[13]}}, {8{st_be_i[12]}}, {8{st_be_i[11]}}, {8{st_be_i[10]}},
                                   {8{st_be_i[9]}}, {8{st_be_i[8]}}, {8{st_be_i[7]}}, {8{st_be_i[6]}},
                                   {8{st_be_i[5]}}, {8{st_be_i[4]}}, {8{st_be_i[3]}}, {8{st_be_i[2]}},
                                   {8{st_be_i[1]}}, {8{st_be_i[0]}}}) | st_data_i;
               q_be[last_idx]   <= q_be[last_idx] | st_be_i;
            end else begin
               q_addr[wp] <= st_addr_i;
               q_data[wp] <= st_data_i;
               q_be[wp]   <= st_be_i;
               last_idx   <= wp;
               wp         <= inc(wp);
            end
            last_multi <= st_multi_i;
         end else if (st_valid_i) begin
            last_multi <= 1'b0;
         end
         if (ub_cap) begin
            ub_pend <= 1'b1;
            ub_addr <= st_addr_i;
            ub_data <= st_data_i;
            ub_be   <= st_be_i;
         end
         case (state)
            S_IDLE: begin
               if (q_issue) begin
                  mem_wr_o    <= 1'b1;
                  mem_waddr_o <= q_addr[rp];
                  mem_wdata_o <= q_data[rp];
                  mem_wbe_o   <= q_be[rp];
                  state       <= S_SEND;
               end else if (ub_issue) begin
                  mem_wr_o    <= 1'b1;
                  mem_waddr_o <= ub_addr;
                  mem_wdata_o <= ub_data;
                  mem_wbe_o   <= ub_be;
                  ub_fly      <= 1'b1;
                  state       <= S_SEND;
               end
            end
            S_SEND: begin
               mem_wr_o <= 1'b0;
               state    <= S_WAIT;
            end
            S_WAIT: begin
               // Abort input is deliberately not looked at here
               if (mem_wack_i) begin
                  state <= S_IDLE;
                  if (ub_fly) begin
                     ub_pend <= 1'b0;
                     ub_fly  <= 1'b0;
                  end else begin
                     rp <= inc(rp);
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   integer j;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (j = 0; j < `CWRB_RB_ENTRIES; j = j + 1) begin
            rb_tag[j] <= 27'h0;
            rb_val[j] <= 8'h00;
         end
         rb_abt      <= 4'h0;
         rb_busy     <= 4'h0;
         f_act       <= 1'b0;
         f_ent       <= 2'h0;
         f_idx       <= 3'h0;
         f_last      <= 3'h0;
         fill_req_o  <= 1'b0;
         fill_addr_o <= 32'h0000_0000;
         ld_hit_o    <= 1'b0;
         ld_data_o   <= 32'h0000_0000;
         ld_abort_o  <= 1'b0;
      end else begin
         if (inval_i) begin
            for (j = 0; j < `CWRB_RB_ENTRIES; j = j + 1) begin
               if (inval_all_i || inval_entry_i == j) begin
                  rb_val[j] <= 8'h00;
                  rb_abt[j] <= 1'b0;
               end
            end
         end
         if (a_go) begin
            for (j = 0; j < `CWRB_RB_ENTRIES; j = j + 1) begin
               if (j != alloc_entry_i && rb_tag[j] == line_of(alloc_addr_i) &&
                   (rb_val[j] & a_span) != 8'h00) begin
                  rb_val[j] <= 8'h00;
               end
            end
            rb_val[alloc_entry_i]  <= 8'h00;
            rb_abt[alloc_entry_i]  <= 1'b0;
            rb_tag[alloc_entry_i]  <= line_of(alloc_addr_i);
            rb_busy[alloc_entry_i] <= 1'b1;
            f_act       <= 1'b1;
            f_ent       <= alloc_entry_i;
            f_idx       <= a_first;
            f_last      <= a_last;
            fill_req_o  <= 1'b1;
            fill_addr_o <= {alloc_addr_i[31:5], a_first, 2'h0};
         end else if (f_act & fill_ack_i) begin
            rb_word[{f_ent, f_idx}] <= fill_data_i;
            rb_val[f_ent][f_idx]    <= 1'b1;
            if (fill_abort_i) begin
               rb_abt[f_ent] <= 1'b1;
            end
            if (f_idx == f_last) begin
               f_act          <= 1'b0;
               rb_busy[f_ent] <= 1'b0;
               fill_req_o     <= 1'b0;
            end else begin
               f_idx       <= f_idx + 3'h1;
               fill_addr_o <= {fill_addr_o[31:5], f_idx + 3'h1, 2'h0};
            end
         end
         // Buffer copy wins over any cache copy; misses fall through
         ld_hit_o   <= ld_valid_i & ~l_stall & (l_hitv != 4'h0);
         ld_data_o  <= rb_word[{l_ent, ld_addr_i[4:2]}];
         ld_abort_o <= ld_valid_i & ~l_stall & (l_hitv != 4'h0) & rb_abt[l_ent];
      end
   end
endmodule
`default_nettype wire

//--- testbench/cwrb_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cwrb_asserts #(
   parameter int DEPTH = 8
) (
   input wire logic        clk_i,          // Core clock
   input wire logic        rst_b_i,        // Reset, active low
   input wire logic [31:0] ctrl_rdata_o,   // Control readback
   input wire logic        st_valid_i,     // Store request
   input wire logic        st_cache_hit_i, // Store hit a cache
   input wire logic        st_prot_ok_i,   // Protection allows
   input wire logic        st_bufable_i,   // Bufferable attribute
   input wire logic        cb_valid_i,     // Copyback request
   input wire logic        drain_i,        // Drain request
   input wire logic        cache_dirty_o,  // Dirty mark
   input wire logic        stall_o,        // Core stall
   input wire logic        wb_empty_o,     // Write buffer empty
   input wire logic        mem_wack_i,     // External write done
   input wire logic        alloc_i,        // Allocate
   input wire logic [1:0]  alloc_size_i,   // Allocate size
   input wire logic        tl_hit_i,       // Translation hit
   input wire logic        tl_viol_i,      // Access violation
   input wire logic        fill_req_o,     // Fill active
   input wire logic [31:0] fill_addr_o     // Fill word address
);
   default clocking dclk @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_reset_clean: assert property ($rose(rst_b_i) |-> wb_empty_o && !stall_o && !ctrl_rdata_o[3])
      else $error("state after reset wrong");
   a_hit_dirty: assert property (st_valid_i && st_cache_hit_i && st_prot_ok_i && !stall_o |=> cache_dirty_o)
      else $error("store hit did not mark the line dirty");
   a_unbuf_stall: assert property (st_valid_i && !st_cache_hit_i && !stall_o
      && !(ctrl_rdata_o[3] && st_bufable_i) |=> stall_o) else $error("unbuffered store did not stall");
   a_buf_continue: assert property (st_valid_i && !st_cache_hit_i && !stall_o && ctrl_rdata_o[3]
      && st_bufable_i && wb_empty_o && !cb_valid_i |=> !stall_o && !wb_empty_o) else $error("store not queued");
   a_copyback_queued: assert property (cb_valid_i && !ctrl_rdata_o[3] && wb_empty_o |=> !wb_empty_o)
      else $error("copyback bypassed the write buffer");
   a_drain_hold: assert property (drain_i && !wb_empty_o && !mem_wack_i |=> stall_o)
      else $error("drain released the core early");
   a_fill_start: assert property (alloc_i && tl_hit_i && !tl_viol_i && !fill_req_o && !stall_o |=> fill_req_o)
      else $error("allocate did not start a fill");
   a_viol_nop: assert property (alloc_i && tl_viol_i && !fill_req_o |=> !fill_req_o)
      else $error("violating allocate started a fill");
   a_line_align: assert property ($rose(fill_req_o) && $past(alloc_size_i) == 2'h3 |-> fill_addr_o[4:0] == 5'h00)
      else $error("line fill not aligned");
endmodule
bind cwrb_top cwrb_asserts #(.DEPTH(DEPTH)) u_cwrb_asserts (.*);
`default_nettype wire

//--- testbench/cwrb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cwrb_mem_model (
   input  wire logic        clk_i,        // Core clock
   input  wire logic        rst_b_i,      // Reset, active low
   input  wire logic        slow_i,       // Stretch write acks and each fill word that follows a fill ack
   input  wire logic        abort_i,      // Flag fill words as aborted
   input  wire logic        wr_req_i,     // External write pulse
   output var  logic        wack_o,       // External write done
   input  wire logic        fill_req_i,   // Fill active
   input  wire logic [31:0] fill_addr_i,  // Fill word address
   output var  logic        fill_ack_o,   // Fill word strobe
   output var  logic [31:0] fill_data_o,  // Fill word
   output var  logic        fill_abort_o  // Fill abort flag
);
   logic [2:0] wcnt;
   logic [2:0] fcnt;
   // Acks every other cycle at most, so a dropped request is never acked twice
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wcnt <= 3'h0;
         fcnt <= 3'h0;
         wack_o <= 1'b0;
         fill_ack_o <= 1'b0;
         fill_data_o <= 32'h0000_0000;
         fill_abort_o <= 1'b0;
      end else begin
         wack_o <= (wcnt == 3'h1);
         wcnt <= wr_req_i ? (slow_i ? 3'h6 : 3'h2) : wcnt - {2'h0, wcnt != 3'h0};
         fill_ack_o <= 1'b0;
         fill_abort_o <= 1'b0;
         // Idle data bus toggles so a stale word is never mistaken for a fresh one
         fill_data_o <= ~fill_data_o;
         if (fill_req_i && !fill_ack_o) begin
            fcnt <= (fcnt != 3'h0) ? fcnt - 3'h1 : (slow_i ? 3'h3 : 3'h0);
            if (fcnt == 3'h0) begin
               fill_ack_o <= 1'b1;
               fill_data_o <= fill_addr_i ^ 32'hA5A5_0000;
               fill_abort_o <= abort_i;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench/cwrb_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cwrb_top_tb_top;
   logic         clk_i, rst_b_i, ctrl_we_i, st_valid_i, st_multi_i, st_cache_hit_i, st_prot_ok_i, st_bufable_i;
   logic         cb_valid_i, drain_i, cache_dirty_o, stall_o, wb_empty_o, mem_wr_o, mem_wack_i, mem_abort_i;
   logic         alloc_i, tl_hit_i, tl_viol_i, inval_i, inval_all_i, fill_req_o, fill_ack_i, fill_abort_i;
   logic         ld_valid_i, ld_hit_o, ld_abort_o, slow, fab;
   logic [1:0]   alloc_entry_i, alloc_size_i, inval_entry_i;
   logic [15:0]  st_be_i, cb_be_i, mem_wbe_o;
   logic [31:0]  ctrl_wdata_i, ctrl_rdata_o, st_addr_i, cb_addr_i, mem_waddr_o, alloc_addr_i, fill_addr_o;
   logic [31:0]  fill_data_i, ld_addr_i, ld_data_o;
   logic [127:0] st_data_i, cb_data_i, mem_wdata_o;
   logic [31:0]  wq[$];
   logic [47:0]  wdq[$];
   int           err_total, total_checks, waited, sw, i;

   cwrb_top #(.DEPTH(8)) u_cwrb_top (.*);
   cwrb_mem_model u_cwrb_mem_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow), .abort_i(fab),
      .wr_req_i(mem_wr_o), .wack_o(mem_wack_i), .fill_req_i(fill_req_o), .fill_addr_i(fill_addr_o),
      .fill_ack_o(fill_ack_i), .fill_data_o(fill_data_i), .fill_abort_o(fill_abort_i));

   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (mem_wr_o === 1'b1) wq.push_back(mem_waddr_o);
   always @(posedge clk_i) if (mem_wr_o === 1'b1) wdq.push_back({mem_wbe_o, mem_wdata_o[31:0]});

   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_low(ref logic s);
      waited = 0;
      while (s !== 1'b0) begin
         tick();
         waited++;
         if (waited > 500) begin
            check(1'b0, 1'b1);
            close_out();
         end
      end
   endtask
   task automatic ctrl_write(input logic [31:0] v);
      ctrl_we_i = 1'b1;
      ctrl_wdata_i = v;
      tick();
      ctrl_we_i = 1'b0;
      tick();
   endtask
   // Leaves the request up so back-to-back stores need no idle edge; caller drops it
   task automatic store(input logic [31:0] a, input logic bf, input logic hit, input logic mul);
      st_valid_i = 1'b1;
      st_addr_i = a;
      st_data_i = {4{a}};
      st_bufable_i = bf;
      st_cache_hit_i = hit;
      st_multi_i = mul;
      tick();
      wait_low(stall_o);
   endtask
   task automatic drain();
      st_valid_i = 1'b0;
      drain_i = 1'b1;
      tick();
      wait_low(stall_o);
      drain_i = 1'b0;
   endtask
   task automatic alloc(input logic [1:0] e, input logic [1:0] sz, input logic [31:0] a, input logic v);
      tick();
      {alloc_i, alloc_entry_i, alloc_size_i, alloc_addr_i, tl_viol_i} = {1'b1, e, sz, a, v};
      tick();
      wait_low(stall_o);
      alloc_i = 1'b0;
   endtask
   task automatic wait_fill();
      tick();
      wait_low(fill_req_o);
   endtask
   task automatic ld(input logic [31:0] a);
      tick();
      ld_valid_i = 1'b1;
      ld_addr_i = a;
      tick();
      wait_low(stall_o);
      ld_valid_i = 1'b0;
   endtask
   task automatic ld_chk(input logic [31:0] a, input logic h);
      ld(a);
      check(ld_hit_o, h);
      if (h)
         check(ld_data_o, a ^ 32'hA5A5_0000);
   endtask

   initial begin
      {clk_i, rst_b_i, ctrl_we_i, st_valid_i, st_multi_i, st_cache_hit_i, st_bufable_i, cb_valid_i} = '0;
      {drain_i, mem_abort_i, alloc_i, tl_viol_i, inval_i, inval_all_i, ld_valid_i, slow, fab} = '0;
      {alloc_entry_i, alloc_size_i, inval_entry_i, ctrl_wdata_i, st_addr_i, alloc_addr_i, ld_addr_i} = '0;
      {err_total, total_checks} = '0;
      {tl_hit_i, st_prot_ok_i, st_be_i, cb_be_i} = {2'b11, 16'hFFFF, 16'h00FF};
      cb_addr_i = 32'h0000_5000;
      cb_data_i = {4{32'hC0C0_5000}};
      repeat (16) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      check(ctrl_rdata_o, 32'h0000_0000);
      check(wb_empty_o, 1'b1);
      ctrl_write(32'h0000_0008);
      check(ctrl_rdata_o, 32'h0000_0008);
      // Slow memory with abort raised: ten stores must overflow eight entries
      {slow, mem_abort_i, sw} = {2'b11, 32'h0};
      store(32'h0000_1000, 1'b1, 1'b0, 1'b0);
      check(waited, 0);
      for (i = 1; i < 10; i++) begin
         store(32'h0000_1000 + i * 64, 1'b1, 1'b0, 1'b0);
         sw += waited;
      end
      check(sw > 0, 1'b1);
      drain();
      mem_abort_i = 1'b0;
      check(wb_empty_o, 1'b1);
      check(wq.size(), 10);
      for (i = 0; i < 10; i++) begin
         check(wq[i], 32'h0000_1000 + i * 64);
         check(wdq[i], {16'hFFFF, 32'h0000_1000 + i * 64});
      end
      wq.delete();
      wdq.delete();
      st_be_i = 16'h000F;
      for (i = 0; i < 4; i++)
         store(32'h0000_3000 + i * 4 - (i == 0 ? 32'h1000 : 0), 1'b1, 1'b0, i >= 2);
      drain();
      check(wq.size(), 3);
      store(32'h0000_4000, 1'b0, 1'b0, 1'b0);
      check(waited > 0 && wb_empty_o === 1'b1 && wq.size() == 4, 1'b1);
      st_valid_i = 1'b0;
      ctrl_write(32'h0000_0000);
      store(32'h0000_4100, 1'b1, 1'b0, 1'b0);
      check(waited > 0, 1'b1);
      st_valid_i = 1'b0;
      cb_valid_i = 1'b1;
      tick();
      cb_valid_i = 1'b0;
      drain();
      check(wq[wq.size() - 1], 32'h0000_5000);
      sw = wq.size();
      store(32'h0000_6000, 1'b1, 1'b1, 1'b0);
      check(cache_dirty_o, 1'b1);
      drain();
      check(wq.size(), sw);
      alloc(2'h0, 2'h3, 32'h0000_8014, 1'b0);
      ld(32'h0000_8000);
      check(waited > 0, 1'b1);
      wait_fill();
      slow = 1'b0;
      for (i = 0; i < 8; i++)
         ld_chk(32'h0000_8000 + i * 4, 1'b1);
      alloc(2'h1, 2'h2, 32'h0000_9018, 1'b0);
      wait_fill();
      ld_chk(32'h0000_9010, 1'b1);
      ld_chk(32'h0000_901C, 1'b1);
      ld_chk(32'h0000_9020, 1'b0);
      alloc(2'h2, 2'h1, 32'h0000_A008, 1'b0);
      wait_fill();
      ld_chk(32'h0000_A008, 1'b1);
      ld_chk(32'h0000_A00C, 1'b0);
      alloc(2'h3, 2'h1, 32'h0000_8004, 1'b0);
      wait_fill();
      ld_chk(32'h0000_8004, 1'b1);
      ld_chk(32'h0000_8000, 1'b0);
      alloc(2'h1, 2'h1, 32'h0000_B000, 1'b0);
      wait_fill();
      ld_chk(32'h0000_9010, 1'b0);
      ld_chk(32'h0000_B000, 1'b1);
      alloc(2'h2, 2'h1, 32'h0000_C000, 1'b1);
      tick();
      check(fill_req_o, 1'b0);
      ld_chk(32'h0000_A008, 1'b1);
      fab = 1'b1;
      alloc(2'h0, 2'h1, 32'h0000_D000, 1'b0);
      wait_fill();
      fab = 1'b0;
      ld(32'h0000_D000);
      check(ld_abort_o, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire
